//--- rtl/ums_defs.svh
// Address map, reset values and frame sizes of the dual serial channel block
`ifndef UMS_DEFS_SVH
`define UMS_DEFS_SVH

// Mode registers at their fixed addresses
`define UMS_OFS_CLOCKED_MODE_CH1 16'hff84
`define UMS_OFS_CLOCKED_MODE_CH2 16'hff85
`define UMS_OFS_ASYNC_MODE_CH1   16'hff88
`define UMS_OFS_ASYNC_MODE_CH2   16'hff89

// Data, status and rate registers, channel 2 sits one above channel 1
`define UMS_OFS_RECEIVE_BUFFER   16'hff70
`define UMS_OFS_TRANSMIT_SHIFT   16'hff72
`define UMS_OFS_ERROR_STATUS     16'hff74
`define UMS_OFS_RATE_GEN_CONTROL 16'hff76

// Reset values
`define UMS_MODE_RESET           8'h00
`define UMS_STATUS_RESET         8'h00
`define UMS_DATA_RESET           8'h00
`define UMS_RATE_RESET           8'h0f

// Parity field values not carried by a struct
`define UMS_PAR_NONE             2'h0
`define UMS_PAR_ZERO             2'h1
`define UMS_PAR_ODD              2'h2
`define UMS_PAR_EVEN             2'h3

// Frame sizes
`define UMS_FRAME_W              12
`define UMS_LAST_BIT_7           3'h6
`define UMS_LAST_BIT_8           3'h7

`endif

//--- rtl/ums_pkg.sv
// Types shared by the dual serial channel block
package ums_pkg;

   // Channel operating mode
   typedef enum logic [1:0] {
      UMS_STOPPED,
      UMS_THREE_WIRE,
      UMS_ASYNC,
      UMS_PROHIBITED
   } ums_mode_t;

   // Receiver sequence
   typedef enum logic [2:0] {
      UMS_RX_IDLE,
      UMS_RX_START,
      UMS_RX_DATA,
      UMS_RX_PARITY,
      UMS_RX_STOP
   } ums_rx_state_t;

   // Asynchronous mode register layout
   typedef struct packed {
      logic       uart_tx_enable;
      logic       uart_rx_enable;
      logic       parity_sel_hi;
      logic       parity_sel_lo;
      logic       char_length_sel;
      logic       stop_length_sel;
      logic       rx_error_irq_mask;
      logic       baud_src_internal;
   } ums_async_mode_t;

   // Clocked mode register layout
   typedef struct packed {
      logic       clocked_tx_enable;
      logic       clocked_rx_enable;
      logic [2:0] zero_hi;
      logic       bit_order_select;
      logic       clocked_clock_select;
      logic       zero_lo;
   } ums_clocked_mode_t;

   // Error status register layout
   typedef struct packed {
      logic [4:0] zero;
      logic       parity_error_flag;
      logic       framing_error_flag;
      logic       overrun_flag;
   } ums_status_t;

   // Register access request
   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } ums_bus_req_t;

   // Transmit frame, sent from bit 0 upward
   typedef struct packed {
      logic [11:0] bits;
      logic [3:0]  len;
   } ums_frame_t;

endpackage : ums_pkg

//--- rtl/ums_dual_channel.sv
// Two asynchronous serial channels with mode switching and register access
//
// Overview of operation
// - A channel runs asynchronous or three-wire mode, never both together.
// - All four enables zero puts the channel in the stopped state.
// - Only clocked enables set selects three-wire clocked mode.
// - Only UART enables set selects asynchronous mode.
// - Two identical channels, differing only in addresses and pins.
// - Mode registers are 8-bit read/write, except clocked mode bits 5:3 and 0 which read zero; all are cleared to zero by reset.
// - Each character follows a start bit; transmit and receive run concurrently.
// - Baud rate comes from a rate generator, optionally dividing the external clock.
// - A selector picks external baud clock or system clock as source.
// - A complete received character is copied into the receive buffer.
// - Seven-bit characters land in buffer bits 0 to 6, bit 7 reads zero.
// - Receive buffer is read as one byte; reset clears it to zero.
// - Seven-bit characters send only bits 0 to 6 of the written byte.
// - Writing the transmit register starts transmission at once.
// - Transmit register takes whole byte writes; reset fills the shift register with ones.
// - The receive shift register is hidden from software.
// - Reception follows the mode register and flags each detected error.
// - Transmitter adds start, optional parity and one or two stops.
// - Parity field: none, zero bit unchecked, odd, or even.
// - Length bit picks 7 or 8 bits; stop bit picks one or two.
// - Clock source bit 0 is external baud clock, 1 is system clock.
// - Buffer read clears flags; unread buffer overwritten sets overrun, and the new frame's errors are flagged too.
`timescale 1ns/100ps
`default_nettype none
`include "ums_defs.svh"

module ums_dual_channel (
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   input  wire logic                  ce,
   input  wire ums_pkg::ums_bus_req_t bus_req,
   output logic [7:0]                 rdata,
   input  wire logic [1:0]            rxd,
   output logic [1:0]                 txd,
   input  wire logic [1:0]            ext_baud_clock_in,
   output logic [1:0]                 tx_done_irq,
   output logic [1:0]                 rx_done_irq,
   output logic [1:0]                 three_wire_mode
);

   ums_pkg::ums_async_mode_t   async_mode_q   [2];
   ums_pkg::ums_clocked_mode_t clocked_mode_q [2];
   ums_pkg::ums_status_t       status_q       [2];
   ums_pkg::ums_rx_state_t     rx_state_q     [2];
   logic [7:0]                 rate_q         [2];
   logic [7:0]                 rx_buf_q       [2];
   logic [7:0]                 rx_shift_q     [2];
   logic [10:0]                tx_shift_q     [2];
   logic [3:0]                 tx_left_q      [2];
   logic [8:0]                 tx_cnt_q       [2];
   logic [8:0]                 rx_cnt_q       [2];
   logic [2:0]                 rx_nbits_q     [2];
   logic [1:0]                 tx_busy_q;
   logic [1:0]                 rx_full_q;
   logic [1:0]                 rx_par_q;
   logic [1:0]                 rx_pe_q;
   logic [1:0]                 ext_prev_q;
   logic [1:0]                 txd_q;
   logic [1:0]                 tx_done_q;
   logic [1:0]                 rx_done_q;
   logic [1:0]                 three_wire_q;
   logic [7:0]                 rdata_q;
   logic [1:0]                 src_tick;
   ums_pkg::ums_mode_t         mode [2];

   // Address match for a register of one channel
   function automatic logic reg_hit(input logic [15:0] a, input logic [15:0] base,
                                    input logic idx);
      reg_hit = (a == (base + {15'h0000, idx}));
   endfunction : reg_hit

   // Mode chosen by the two enable pairs
   function automatic ums_pkg::ums_mode_t mode_of(input ums_pkg::ums_async_mode_t a,
                                                  input ums_pkg::ums_clocked_mode_t c);
      logic u;
      logic k;
      u = a.uart_tx_enable | a.uart_rx_enable;
      k = c.clocked_tx_enable | c.clocked_rx_enable;
      if (!u && !k) begin
         mode_of = ums_pkg::UMS_STOPPED;
      end else if (!u) begin
         mode_of = ums_pkg::UMS_THREE_WIRE;
      end else if (!k) begin
         mode_of = ums_pkg::UMS_ASYNC;
      end else begin
         mode_of = ums_pkg::UMS_PROHIBITED;
      end
   endfunction : mode_of

   // Bit period of the rate generator in source ticks
   function automatic logic [8:0] period_of(input logic [7:0] r);
      period_of = {1'b0, r} + 9'h001;
   endfunction : period_of

   // Frame builder: start, character, parity, stops
   function automatic ums_pkg::ums_frame_t build_frame(input logic [7:0] d,
                                                       input ums_pkg::ums_async_mode_t m);
      ums_pkg::ums_frame_t f;
      logic [1:0]          ps;
      logic [7:0]          dd;
      logic [3:0]          pos;
      logic                par;
      ps     = {m.parity_sel_hi, m.parity_sel_lo};
      dd     = m.char_length_sel ? d : {1'b0, d[6:0]};
      f.bits = 12'hfff;
      f.bits[0] = 1'b0;
      if (m.char_length_sel) begin
         f.bits[8:1] = dd;
         pos = 4'h9;
      end else begin
         f.bits[7:1] = dd[6:0];
         pos = 4'h8;
      end
      unique case (ps)
         `UMS_PAR_NONE: par = 1'b1;
         `UMS_PAR_ZERO: par = 1'b0;
         `UMS_PAR_ODD:  par = ~(^dd);
         `UMS_PAR_EVEN: par = ^dd;
      endcase
      if (ps != `UMS_PAR_NONE) begin
         f.bits[pos] = par;
         pos = pos + 4'h1;
      end
      f.len = pos + (m.stop_length_sel ? 4'h2 : 4'h1);
      build_frame = f;
   endfunction : build_frame

   // Per-channel mode decode and baud source selection
   always_comb begin
      for (int ch = 0; ch < 2; ch++) begin
         mode[ch] = mode_of(async_mode_q[ch], clocked_mode_q[ch]);
         src_tick[ch] = async_mode_q[ch].baud_src_internal
                        | (ext_baud_clock_in[ch] & ~ext_prev_q[ch]);
      end
   end

   // External baud clock edge memory
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ext_prev_q <= 2'h0;
      end else if (ce) begin
         ext_prev_q <= ext_baud_clock_in;
      end
   end

   // Mode and rate registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int ch = 0; ch < 2; ch++) begin
            async_mode_q[ch]   <= `UMS_MODE_RESET;
            clocked_mode_q[ch] <= `UMS_MODE_RESET;
            rate_q[ch]         <= `UMS_RATE_RESET;
         end
      end else if (ce && bus_req.wr) begin
         for (int ch = 0; ch < 2; ch++) begin
            if (reg_hit(bus_req.addr, `UMS_OFS_ASYNC_MODE_CH1, 1'(ch))) begin
               async_mode_q[ch] <= bus_req.wdata;
            end
            if (reg_hit(bus_req.addr, `UMS_OFS_CLOCKED_MODE_CH1, 1'(ch))) begin
               clocked_mode_q[ch] <= {bus_req.wdata[7:6], 3'h0, bus_req.wdata[2:1], 1'b0};
            end
            if (reg_hit(bus_req.addr, `UMS_OFS_RATE_GEN_CONTROL, 1'(ch))) begin
               rate_q[ch] <= bus_req.wdata;
            end
         end
      end
   end

   // Transmitter: load on write, shift out one bit per period
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_busy_q <= 2'h0;
         txd_q     <= 2'h3;
         tx_done_q <= 2'h0;
         for (int ch = 0; ch < 2; ch++) begin
            tx_shift_q[ch] <= 11'h7ff;
            tx_left_q[ch]  <= 4'h0;
            tx_cnt_q[ch]   <= 9'h000;
         end
      end else if (ce) begin
         tx_done_q <= 2'h0;
         for (int ch = 0; ch < 2; ch++) begin
            if (mode[ch] != ums_pkg::UMS_ASYNC || !async_mode_q[ch].uart_tx_enable) begin
               tx_busy_q[ch] <= 1'b0;
               txd_q[ch]     <= 1'b1;
            end else if (!tx_busy_q[ch]) begin
               txd_q[ch] <= 1'b1;
               if (bus_req.wr && reg_hit(bus_req.addr, `UMS_OFS_TRANSMIT_SHIFT, 1'(ch))) begin
                  tx_busy_q[ch]  <= 1'b1;
                  txd_q[ch]      <= 1'b0;
                  tx_shift_q[ch] <= build_frame(bus_req.wdata, async_mode_q[ch]).bits[11:1];
                  tx_left_q[ch]  <= build_frame(bus_req.wdata, async_mode_q[ch]).len - 4'h1;
                  tx_cnt_q[ch]   <= period_of(rate_q[ch]) - 9'h001;
               end
            end else if (src_tick[ch]) begin
               if (tx_cnt_q[ch] != 9'h000) begin
                  tx_cnt_q[ch] <= tx_cnt_q[ch] - 9'h001;
               end else if (tx_left_q[ch] != 4'h0) begin
                  txd_q[ch]      <= tx_shift_q[ch][0];
                  tx_shift_q[ch] <= {1'b1, tx_shift_q[ch][10:1]};
                  tx_left_q[ch]  <= tx_left_q[ch] - 4'h1;
                  tx_cnt_q[ch]   <= period_of(rate_q[ch]) - 9'h001;
               end else begin
                  tx_busy_q[ch] <= 1'b0;
                  txd_q[ch]     <= 1'b1;
                  tx_done_q[ch] <= 1'b1;
               end
            end
         end
      end
   end

   // Receiver sequence, shift register and parity accumulation
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_par_q  <= 2'h0;
         rx_pe_q   <= 2'h0;
         rx_done_q <= 2'h0;
         rx_full_q <= 2'h0;
         for (int ch = 0; ch < 2; ch++) begin
            rx_state_q[ch] <= ums_pkg::UMS_RX_IDLE;
            rx_shift_q[ch] <= `UMS_DATA_RESET;
            rx_buf_q[ch]   <= `UMS_DATA_RESET;
            rx_cnt_q[ch]   <= 9'h000;
            rx_nbits_q[ch] <= 3'h0;
            status_q[ch]   <= `UMS_STATUS_RESET;
         end
      end else if (ce) begin
         rx_done_q <= 2'h0;
         for (int ch = 0; ch < 2; ch++) begin
            // Buffer read clears flags, a completing frame below overrides
            if (bus_req.rd && reg_hit(bus_req.addr, `UMS_OFS_RECEIVE_BUFFER, 1'(ch))) begin
               status_q[ch]  <= `UMS_STATUS_RESET;
               rx_full_q[ch] <= 1'b0;
            end
            if (mode[ch] != ums_pkg::UMS_ASYNC || !async_mode_q[ch].uart_rx_enable) begin
               rx_state_q[ch] <= ums_pkg::UMS_RX_IDLE;
            end else begin
               unique case (rx_state_q[ch])
                  ums_pkg::UMS_RX_IDLE: begin
                     if (!rxd[ch]) begin
                        rx_state_q[ch] <= ums_pkg::UMS_RX_START;
                        rx_cnt_q[ch]   <= period_of(rate_q[ch]) >> 1;
                     end
                  end
                  default: begin
                     if (src_tick[ch] && rx_cnt_q[ch] != 9'h000) begin
                        rx_cnt_q[ch] <= rx_cnt_q[ch] - 9'h001;
                     end else if (src_tick[ch]) begin
                        rx_cnt_q[ch] <= period_of(rate_q[ch]) - 9'h001;
                        unique case (rx_state_q[ch])
                           ums_pkg::UMS_RX_START: begin
                              rx_nbits_q[ch] <= 3'h0;
                              rx_par_q[ch]   <= 1'b0;
                              rx_state_q[ch] <= rxd[ch] ? ums_pkg::UMS_RX_IDLE
                                                        : ums_pkg::UMS_RX_DATA;
                           end
                           ums_pkg::UMS_RX_DATA: begin
                              rx_shift_q[ch] <= {rxd[ch], rx_shift_q[ch][7:1]};
                              rx_par_q[ch]   <= rx_par_q[ch] ^ rxd[ch];
                              rx_nbits_q[ch] <= rx_nbits_q[ch] + 3'h1;
                              if (rx_nbits_q[ch] == (async_mode_q[ch].char_length_sel
                                                     ? `UMS_LAST_BIT_8 : `UMS_LAST_BIT_7)) begin
                                 rx_state_q[ch] <= ({async_mode_q[ch].parity_sel_hi,
                                                     async_mode_q[ch].parity_sel_lo}
                                                    == `UMS_PAR_NONE)
                                                   ? ums_pkg::UMS_RX_STOP
                                                   : ums_pkg::UMS_RX_PARITY;
                              end
                           end
                           ums_pkg::UMS_RX_PARITY: begin
                              unique case ({async_mode_q[ch].parity_sel_hi,
                                            async_mode_q[ch].parity_sel_lo})
                                 `UMS_PAR_ODD:  rx_pe_q[ch] <= ~(rx_par_q[ch] ^ rxd[ch]);
                                 `UMS_PAR_EVEN: rx_pe_q[ch] <= rx_par_q[ch] ^ rxd[ch];
                                 default:       rx_pe_q[ch] <= 1'b0;
                              endcase
                              rx_state_q[ch] <= ums_pkg::UMS_RX_STOP;
                           end
                           ums_pkg::UMS_RX_STOP: begin
                              rx_state_q[ch] <= ums_pkg::UMS_RX_IDLE;
                              rx_full_q[ch]  <= 1'b1;
                              rx_buf_q[ch]   <= async_mode_q[ch].char_length_sel
                                                ? rx_shift_q[ch]
                                                : {1'b0, rx_shift_q[ch][7:1]};
                              // Unread buffer gives overrun; the new frame's errors stand
                              status_q[ch].overrun_flag <= rx_full_q[ch]
                                 & ~(bus_req.rd && reg_hit(bus_req.addr,
                                     `UMS_OFS_RECEIVE_BUFFER, 1'(ch)));
                              status_q[ch].framing_error_flag <= ~rxd[ch];
                              status_q[ch].parity_error_flag  <= rx_pe_q[ch];
                              rx_done_q[ch] <= ~(async_mode_q[ch].rx_error_irq_mask
                                                 & (~rxd[ch] | rx_pe_q[ch]));
                           end
                           default: rx_state_q[ch] <= ums_pkg::UMS_RX_IDLE;
                        endcase
                     end
                  end
               endcase
            end
            if (rx_state_q[ch] != ums_pkg::UMS_RX_PARITY
                && rx_state_q[ch] != ums_pkg::UMS_RX_STOP) begin
               rx_pe_q[ch] <= 1'b0;
            end
         end
      end
   end

   // Three-wire mode indication per channel
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         three_wire_q <= 2'h0;
      end else if (ce) begin
         for (int ch = 0; ch < 2; ch++) begin
            three_wire_q[ch] <= (mode[ch] == ums_pkg::UMS_THREE_WIRE);
         end
      end
   end

   // Registered read data, unmapped and write-only addresses read zero
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= 8'h00;
      end else if (ce) begin
         rdata_q <= 8'h00;
         if (bus_req.rd) begin
            for (int ch = 0; ch < 2; ch++) begin
               if (reg_hit(bus_req.addr, `UMS_OFS_ASYNC_MODE_CH1, 1'(ch))) begin
                  rdata_q <= async_mode_q[ch];
               end
               if (reg_hit(bus_req.addr, `UMS_OFS_CLOCKED_MODE_CH1, 1'(ch))) begin
                  rdata_q <= clocked_mode_q[ch];
               end
               if (reg_hit(bus_req.addr, `UMS_OFS_RATE_GEN_CONTROL, 1'(ch))) begin
                  rdata_q <= rate_q[ch];
               end
               if (reg_hit(bus_req.addr, `UMS_OFS_ERROR_STATUS, 1'(ch))) begin
                  rdata_q <= status_q[ch];
               end
               if (reg_hit(bus_req.addr, `UMS_OFS_RECEIVE_BUFFER, 1'(ch))) begin
                  rdata_q <= rx_buf_q[ch];
               end
            end
         end
      end
   end

   // Outputs straight from flip-flops
   assign rdata           = rdata_q;
   assign txd             = txd_q;
   assign tx_done_irq     = tx_done_q;
   assign rx_done_irq     = rx_done_q;
   assign three_wire_mode = three_wire_q;

endmodule : ums_dual_channel

`default_nettype wire

//--- tb/ums_monitor.sv
// Port checker for the dual serial channel block
`timescale 1ns/100ps
`default_nettype none
module ums_monitor (
   input wire logic                  clk,
   input wire logic                  rst_n,
   input wire logic                  ce,
   input wire ums_pkg::ums_bus_req_t bus_req,
   input wire logic [7:0]            rdata,
   input wire logic [1:0]            rxd,
   input wire logic [1:0]            txd,
   input wire logic [1:0]            ext_baud_clock_in,
   input wire logic [1:0]            tx_done_irq,
   input wire logic [1:0]            rx_done_irq,
   input wire logic [1:0]            three_wire_mode
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire logic rd_take = ce && bus_req.rd;
   // Read data path
   rd_idle_a: assert property (ce && !bus_req.rd |=> rdata == 8'h00)
      else $error("read data not cleared");
   unmapped_rd_a: assert property (rd_take && bus_req.addr inside {[16'hff78:16'hff83]}
      |=> rdata == 8'h00) else $error("unmapped read not zero");
   wo_read_a: assert property (rd_take && bus_req.addr[15:1] == 15'h7fb9
      |=> rdata == 8'h00) else $error("transmit register readable");
   zero_fields_a: assert property (rd_take && bus_req.addr[15:1] == 15'h7fc2
      |=> (rdata & 8'h39) == 8'h00) else $error("fixed clocked mode bits set");
   // Serial lines against mode and completion
   tw_idle_a: assert property ((three_wire_mode & ~txd) == 2'b00)
      else $error("line active in three-wire mode");
   done_idle_a: assert property ((tx_done_irq & ~txd) == 2'b00)
      else $error("line low at transmit done");
   tx_pulse_a: assert property (ce |=> (tx_done_irq & $past(tx_done_irq)) == 2'b00)
      else $error("transmit done longer than a cycle");
   rx_pulse_a: assert property (ce |=> (rx_done_irq & $past(rx_done_irq)) == 2'b00)
      else $error("receive done longer than a cycle");
   tx_refused_a: assert property (ce && bus_req.wr && bus_req.addr == 16'hff72
      && three_wire_mode[0] |=> txd[0] [*2]) else $error("transmit started off mode");
   // Main scenarios
   tx_cov: cover property (tx_done_irq[0]);
   rx_cov: cover property (rx_done_irq[0]);
   tw_cov: cover property (three_wire_mode == 2'b11);
endmodule : ums_monitor
bind ums_dual_channel ums_monitor u_mon (.clk(clk), .rst_n(rst_n), .ce(ce), .bus_req(bus_req),
   .rdata(rdata), .rxd(rxd), .txd(txd), .ext_baud_clock_in(ext_baud_clock_in),
   .tx_done_irq(tx_done_irq), .rx_done_irq(rx_done_irq), .three_wire_mode(three_wire_mode));
`default_nettype wire

//--- tb/ums_serial_node.sv
// Remote serial node: sends frames on a line and samples the other
`timescale 1ns/100ps
`default_nettype none
module ums_serial_node #(
   parameter int BIT_CYC = 4
) (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        send,
   input  wire logic [11:0] frame,
   output logic             line_out,
   input  wire logic        line_in,
   output logic [11:0]      cap,
   output logic             cap_ok
);
   int          n;
   int          ph;
   int          cph;
   logic [11:0] sh;
   logic        cbusy;
   // Sender, bit 0 first, line back high after the frame
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         line_out <= 1'b1;
         n        <= 12;
      end else if (send) begin
         sh <= frame;
         n  <= 0;
         ph <= 0;
      end else if (n < 13) begin
         if (ph == 0) begin
            line_out <= (n < 12) ? sh[n] : 1'b1;
            n        <= n + 1;
         end
         ph <= (ph + 1) % BIT_CYC;
      end
   end
   // Sampler, mid-bit after the start edge, twelve bits
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cbusy  <= 1'b0;
         cap_ok <= 1'b0;
      end else if (!cbusy && !line_in) begin
         cbusy  <= 1'b1;
         cap_ok <= 1'b0;
         cph    <= 1;
      end else if (cbusy) begin
         cph <= cph + 1;
         if (cph % BIT_CYC == 2)
            cap[cph / BIT_CYC] <= line_in;
         if (cph == BIT_CYC * 11 + 2) begin
            cbusy  <= 1'b0;
            cap_ok <= 1'b1;
         end
      end
   end
endmodule : ums_serial_node
`default_nettype wire

//--- tb/uart_sio_mode_switch_datapath_bench.sv
// Self-checking bench for the dual serial channel block
`timescale 1ns/100ps
`default_nettype none
module uart_sio_mode_switch_datapath_bench;
   logic                  clk = 1'b0;
   logic                  rst_n = 1'b0;
   logic                  ce = 1'b1;
   ums_pkg::ums_bus_req_t bus_req = '0;
   logic [7:0]            rdata, d, r, cfg;
   logic [1:0]            txd, tx_done_irq, rx_done_irq, three_wire_mode;
   logic [1:0]            ext_baud_clock_in = 2'b00;
   logic                  send = 1'b0;
   logic [11:0]           frame = 12'hfff;
   wire  [1:0]            rxd, cdone;
   wire  [11:0]           cap [2];
   int                    err_count = 0, comparisons = 0, cyc = 0, seed = 32'h109e;
   localparam logic [15:0] ADR [4] = '{16'hff84, 16'hff85, 16'hff88, 16'hff89};
   localparam logic [7:0]  EC [3] = '{8'hf9, 8'hdb, 8'hc9};
   localparam logic [7:0]  ES [3] = '{8'h04, 8'h00, 8'h02};
   always #4 clk = ~clk;
   always @(posedge clk) ext_baud_clock_in <= ~ext_baud_clock_in;
   // Hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         end_sim();
      end
   end
   ums_dual_channel DUT (.clk(clk), .rst_n(rst_n), .ce(ce), .bus_req(bus_req), .rdata(rdata),
      .rxd(rxd), .txd(txd), .ext_baud_clock_in(ext_baud_clock_in), .tx_done_irq(tx_done_irq),
      .rx_done_irq(rx_done_irq), .three_wire_mode(three_wire_mode));
   ums_serial_node #(.BIT_CYC(4)) u_node1 (.clk(clk), .rst_n(rst_n), .send(send),
      .frame(frame), .line_out(rxd[0]), .line_in(txd[0]), .cap(cap[0]), .cap_ok(cdone[0]));
   ums_serial_node #(.BIT_CYC(4)) u_node2 (.clk(clk), .rst_n(rst_n), .send(1'b0),
      .frame(frame), .line_out(rxd[1]), .line_in(txd[1]), .cap(cap[1]), .cap_ok(cdone[1]));
   // Expected line pattern: start, data, parity, stop and idle ones
   function automatic logic [11:0] mkframe(input logic [7:0] dv, input logic [7:0] c);
      logic [11:0] f;
      logic        p;
      int          n;
      f = 12'hffe;
      n = c[3] ? 8 : 7;
      p = (c[5:4] == 2'h2);
      for (int i = 0; i < n; i++) begin
         f[i + 1] = dv[i];
         p ^= dv[i];
      end
      if (c[5:4] != 2'h0) f[n + 1] = (c[5:4] == 2'h1) ? 1'b0 : p;
      return f;
   endfunction : mkframe
   task automatic check(input logic [11:0] seen, input logic [11:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic acc(input logic rd, input logic [15:0] a, input logic [7:0] w);
      @(posedge clk);
      bus_req <= '{rd, ~rd, a, w};
      @(posedge clk);
      bus_req <= '0;
      #1;
   endtask : acc
   task automatic send_rx(input logic [11:0] f);
      @(posedge clk);
      frame <= f;
      send <= 1'b1;
      @(posedge clk);
      send <= 1'b0;
   endtask : send_rx
   task automatic wait_ev(input int w);
      int i;
      for (i = 0; i < 400; i++) begin
         @(posedge clk);
         #1;
         if ((w == 0 && rx_done_irq[0]) || (w > 0 && cdone[w - 1])) break;
      end
      check(12'(i < 400), 12'h001);
   endtask : wait_ev
   task automatic end_sim();
      $display("comparisons %0d err_count %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : end_sim
   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      foreach (ADR[i]) begin
         acc(1'b1, ADR[i], 8'h00);
         check(rdata, 8'h00);
         r = 8'($random(seed));
         acc(1'b0, ADR[i], r);
         acc(1'b1, ADR[i], 8'h00);
         check(rdata, r & ((i < 2) ? 8'hc6 : 8'hff));
         acc(1'b0, ADR[i], 8'h00);
      end
      acc(1'b0, 16'hff84, 8'h80);
      acc(1'b0, 16'hff72, 8'h55);
      acc(1'b0, 16'hff85, 8'h40);
      repeat (3) @(posedge clk);
      #1;
      check(three_wire_mode, 2'b11);
      check(txd, 2'b11);
      acc(1'b0, 16'hff84, 8'h00);
      acc(1'b0, 16'hff85, 8'h00);
      repeat (3) @(posedge clk);
      #1;
      check(three_wire_mode, 2'b00);
      acc(1'b0, 16'hff76, 8'h03);
      acc(1'b0, 16'hff77, 8'h01);
      acc(1'b1, 16'hff7a, 8'h00);
      check(rdata, 8'h00);
      acc(1'b1, 16'hff72, 8'h00);
      check(rdata, 8'h00);
      // Full duplex on channel 1, every parity mode, random length and stops
      for (int i = 0; i < 4; i++) begin
         cfg = {2'b11, 2'(i), 2'($random(seed)), 2'b01};
         d = 8'($random(seed));
         acc(1'b0, 16'hff88, cfg);
         check(three_wire_mode, 2'b00);
         check(txd[0], 1'b1);
         acc(1'b0, 16'hff72, d);
         send_rx(mkframe(d, cfg));
         wait_ev(0);
         acc(1'b1, 16'hff74, 8'h00);
         check(rdata, 8'h00);
         acc(1'b1, 16'hff70, 8'h00);
         check(rdata, cfg[3] ? d : {1'b0, d[6:0]});
         wait_ev(1);
         check(cap[0], mkframe(d, cfg));
      end
      // Channel 2 sends on the external baud clock
      acc(1'b0, 16'hff89, 8'h88);
      d = 8'($random(seed));
      acc(1'b0, 16'hff73, d);
      wait_ev(2);
      check(cap[1], mkframe(d, 8'h88));
      // Corrupted bit 9: parity, masked zero parity, stop
      foreach (EC[i]) begin
         d = 8'($random(seed));
         acc(1'b0, 16'hff88, EC[i]);
         send_rx(mkframe(d, EC[i]) ^ 12'h200);
         wait_ev(0);
         acc(1'b1, 16'hff74, 8'h00);
         check(rdata, ES[i]);
         acc(1'b1, 16'hff70, 8'h00);
      end
      send_rx(mkframe(8'h3c, 8'hc9));
      wait_ev(0);
      send_rx(mkframe(8'hc3, 8'hc9));
      wait_ev(0);
      acc(1'b1, 16'hff74, 8'h00);
      check(rdata, 8'h01);
      acc(1'b1, 16'hff70, 8'h00);
      check(rdata, 8'hc3);
      acc(1'b1, 16'hff74, 8'h00);
      check(rdata, 8'h00);
      end_sim();
   end
endmodule : uart_sio_mode_switch_datapath_bench
`default_nettype wire
